/* File: bench/ecp_peripheral.sv */
`timescale 1ns/1ps
`default_nettype none
//--------------------
// cable peripheral model
//--------------------
module ecp_peripheral (
    input  wire logic       clk,
    input  wire logic       dir,
    input  wire logic       hold,
    input  wire logic [3:0] lag,
    input  wire logic       stb_w,
    input  wire logic       afd_w,
    input  wire logic [7:0] pd_w,
    output var  logic       busy,
    output var  logic       ack_n,
    output var  logic [7:0] pd_drv
);
    logic [8:0] q[$];
    logic [8:0] got = 9'h000;
    logic [3:0] cnt = 4'h0;
    logic       bad = 1'b0;
    logic       cyc = 1'b0;
    logic       bk = 1'b0;
    int         n_stb = 0;
    initial begin
        busy = 1'b0;
        ack_n = 1'b1;
        pd_drv = 8'h5A;
    end
    always @(posedge clk) begin
        if (!dir) begin
            if (!cyc && !stb_w) begin
                got <= {afd_w, pd_w};
                n_stb <= n_stb + 1;
                cyc <= 1'b1;
                cnt <= 4'h0;
            end else if (cyc && stb_w) begin
                busy <= 1'b0;
                cyc <= 1'b0;
            end else if (cyc && !hold) begin
                cnt <= cnt + 4'h1;
                busy <= busy | (cnt == lag);
            end
            // strobe released early, or lines moved while busy high
            if ((cyc && stb_w && !busy && !hold) || (busy && {afd_w, pd_w} !== got))
                bad <= 1'b1;
        end else if (!bk && q.size() > 0 && !afd_w) begin
            {busy, pd_drv} <= q.pop_front();
            ack_n <= 1'b0;
            bk <= 1'b1;
        end else if (bk && !ack_n && afd_w) begin
            ack_n <= 1'b1;
        end else if (bk && ack_n && !afd_w) begin
            bk <= 1'b0;
        end else if (!bk) begin
            pd_drv <= ~pd_drv;
        end
    end
endmodule // ecp_peripheral
`default_nettype wire

/* File: bench/test_ecp_parallel_port_transfer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecp_map.svh"
//--------------------
// port bench
//--------------------
module test_ecp_parallel_port_transfer;
    import ecp_pkg::*;
    logic       SYS_CLK = 0, RST = 1, DMA_ACK = 0, p_dir = 0, p_hold = 0;
    logic [3:0] p_lag = 4'h0;
    logic       p_busy, p_ack_n, dma_req;
    logic [7:0] p_pd, dma_rd, d;
    logic [1:0] r;
    axil_req_t  req = '0;
    axil_rsp_t  rsp;
    pins_t      out, oe;
    cable_in_t  cin;
    int         n_mismatch = 0, checks = 0, i, n;

    // controls pulled up when released, data from whoever drives
    assign cin = {p_ack_n, p_busy, 3'b011, out.ctl & oe.ctl | ~oe.ctl, out.pd & oe.pd | p_pd & ~oe.pd};
    always #2.5 SYS_CLK = ~SYS_CLK;

    ecp_port dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .AXI_REQ(req), .AXI_RSP(rsp), .CABLE_IN(cin),
        .CABLE_OUT(out), .CABLE_OE(oe), .DMA_ACK(DMA_ACK), .DMA_WDATA(8'h00), .DMA_REQ(dma_req),
        .DMA_RDATA(dma_rd));
    ecp_peripheral p_u (.clk(SYS_CLK), .dir(p_dir), .hold(p_hold), .lag(p_lag), .stb_w(cin.ctl[0]),
        .afd_w(cin.ctl[1]), .pd_w(cin.pd), .busy(p_busy), .ack_n(p_ack_n), .pd_drv(p_pd));

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 300) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int k;
        @(posedge SYS_CLK);
        req <= {1'b1, a, 1'b1, 24'h0, v, 4'hF, 1'b1, 10'h0};
        for (k = 0; k < 300; k++) begin
            @(posedge SYS_CLK);
            if (rsp.bvalid)
                break;
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
        end
        req <= '0;
        tmo(k);
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge SYS_CLK);
        req <= {47'h0, 1'b1, a, 1'b1};
        for (k = 0; k < 300; k++) begin
            @(posedge SYS_CLK);
            if (rsp.rvalid)
                break;
            if (rsp.arready)
                req.arvalid <= 1'b0;
        end
        d = rsp.rdata[7:0];
        r = rsp.rresp;
        req <= '0;
        tmo(k);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        rd(a);
        chk({r, d}, {`RESP_OK, x});
    endtask
    task automatic wstb(input int k);
        for (i = 0; i < 300 && p_u.n_stb < k; i++) @(posedge SYS_CLK);
        tmo(i);
    endtask

    initial begin
        repeat (20) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        rc(8'h14, 8'h15);
        rc(8'h08, 8'h00);
        chk({oe.ctl, oe.pd}, 12'h4FF);
        wr(8'h00, 8'hA5);
        rc(8'h00, 8'hA5);
        chk(out.pd, 8'hA5);
        rd(8'h18);
        chk(r, `RESP_ERR);
        wr(8'h10, 8'h5A);
        rc(8'h10, 8'h00);
        wr(8'h14, 8'hE0);
        rc(8'h0C, `CFGA_VAL);
        wr(8'h10, 8'h5A);
        rc(8'h10, 8'h5A);
        wr(8'h14, 8'hC0);
        wr(8'h0C, 8'h9A);
        wr(8'h0C, 8'h9B);
        rc(8'h0C, 8'h9A);
        rc(8'h0C, 8'h9B);
        chk(16'(p_u.n_stb), 16'h0);
        wr(8'h14, 8'hB8);
        wr(8'h0C, 8'h11);
        rc(8'h14, 8'hB9);
        chk(dma_req, 1'b0);
        p_hold <= 1'b1;
        wr(8'h14, 8'h44);
        wr(8'h0C, 8'hC3);
        for (i = 0; i < 300 && out.ctl[0]; i++) @(posedge SYS_CLK);
        tmo(i);
        for (n = 0; n < 300 && !out.ctl[0]; n++) @(posedge SYS_CLK);
        chk(16'(n), 16'(`STB_CYC));
        chk({p_u.got, oe.ctl}, {9'h1C3, 4'hF});
        p_hold <= 1'b0;
        p_lag <= 4'h6;
        wr(8'h14, 8'h74);
        wr(8'h0C, 8'h3C);
        wstb(2);
        chk(p_u.got, 9'h13C);
        wr(8'h00, 8'h12);
        wstb(3);
        chk(p_u.got, 9'h012);
        // let the command cycle finish before the direction turns
        for (i = 0; i < 300 && p_u.cyc; i++) @(posedge SYS_CLK);
        tmo(i);
        rc(8'h14, 8'h75);
        p_u.q = '{9'h155, 9'h085, 9'h002, 9'h077};
        wr(8'h08, 8'h20);
        p_dir <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        for (i = 0; i < 300 && (p_u.q.size() > 0 || p_u.bk); i++) @(posedge SYS_CLK);
        tmo(i);
        wr(8'h14, 8'h78);
        for (i = 0; i < 300 && !dma_req; i++) @(posedge SYS_CLK);
        chk(dma_req, 1'b1);
        DMA_ACK <= 1'b1;
        @(posedge SYS_CLK);
        DMA_ACK <= 1'b0;
        @(posedge SYS_CLK);
        chk(dma_rd, 8'h55);
        rc(8'h0C, 8'h77);
        rc(8'h0C, 8'h77);
        rc(8'h0C, 8'h77);
        rc(8'h14, 8'h79);
        wr(8'h14, 8'h20);
        rc(8'h08, 8'h20);
        chk({oe.ctl, oe.pd}, 12'hF00);
        wr(8'h08, 8'h00);
        wr(8'h14, 8'h80);
        rc(8'h04, 8'hD8);
        wr(8'h00, 8'h3E);
        rc(8'h00, 8'h3E);
        chk({oe.ctl, oe.pd}, 12'hFFF);
        chk(p_u.bad, 1'b0);
        results();
    end
endmodule // test_ecp_parallel_port_transfer
`default_nettype wire

/* File: design/ecp_fifo_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecp_map.svh"

module ecp_fifo_mem (
    input  wire logic                clk,
    input  wire logic                we,
    input  wire logic [`FIFO_AW-1:0] wa,
    input  wire logic [8:0]          wd,
    input  wire logic [`FIFO_AW-1:0] ra,
    output var  logic [8:0]          rd_q
);

    logic [8:0] mem [`FIFO_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
        rd_q <= mem[ra];
    end

endmodule // ecp_fifo_mem

`default_nettype wire

/* File: design/ecp_map.svh */
`ifndef ECP_MAP_SVH
`define ECP_MAP_SVH

// register indices, byte address is four times the index
`define IDX_DATA     6'h00
`define IDX_STAT     6'h01
`define IDX_CTRL     6'h02
`define IDX_FIFO     6'h03
`define IDX_CFGB     6'h04
`define IDX_ECR      6'h05
`define IDX_LAST     6'h05

// control register fields
`define C_STB        0
`define C_AFD        1
`define C_INIT       2
`define C_SELECT_IN_LINE       3
`define C_IRQ        4
`define C_DIR        5

// extended control, stored bits 7..2
`define ECR_RST      6'h05
`define CTRL_RST     8'h00
`define DATA_RST     8'h00
`define CFGB_RST     8'h00
// arbitrary value
`define CFGA_VAL     8'h10

`define CLK_NS       5
`define STB_PULSE_NS 500
`define STB_CYC      ((`STB_PULSE_NS + `CLK_NS - 1) / `CLK_NS)

`define FIFO_DEPTH   16
`define FIFO_AW      4
`define RESP_OK      2'h0
`define RESP_ERR     2'h2

`endif

/* File: design/ecp_pkg.sv */
package ecp_pkg;

    typedef enum logic [2:0] {
        M_STD, M_BIDIR, M_PPF, M_ECP, M_EPP, M_RSV, M_TEST, M_CFG
    } mode_t;

    typedef enum logic [1:0] {F_IDLE, F_SETUP, F_STB, F_END} fst_t;
    typedef enum logic [2:0] {B_IDLE, B_REQ, B_ACK, B_LATCH, B_EXP} bst_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    // ctl: 0 write_strobe, 1 autofeed_line, 2 init, 3 select_in_line (pin levels)
    typedef struct packed {
        logic [3:0] ctl;
        logic [7:0] pd;
    } pins_t;

    typedef struct packed {
        logic       ack_n;
        logic       busy;
        logic       pe;
        logic       slct;
        logic       err_n;
        logic [3:0] ctl;
        logic [7:0] pd;
    } cable_in_t;

endpackage

/* File: design/ecp_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecp_map.svh"

//------------------------------------------------------------
//------------------------------------------------------------

module ecp_port (
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    input  wire ecp_pkg::axil_req_t AXI_REQ,
    output var  ecp_pkg::axil_rsp_t AXI_RSP,
    input  wire ecp_pkg::cable_in_t CABLE_IN,
    output var  ecp_pkg::pins_t    CABLE_OUT,
    output var  ecp_pkg::pins_t    CABLE_OE,
    input  wire logic              DMA_ACK,
    input  wire logic [7:0]        DMA_WDATA,
    output var  logic              DMA_REQ,
    output var  logic [7:0]        DMA_RDATA
);
    import ecp_pkg::*;

    localparam logic [6:0] STB_LAST = 7'(`STB_CYC - 1);

    //--------------------------------------------------------
    // registers and mode decode
    //--------------------------------------------------------
    logic [7:0] data_q;
    logic [7:0] ctrl_q;
    logic [7:0] cfgb_q;
    logic [5:0] ecr_q;
    mode_t      mode;
    logic       dir_eff;
    logic       fifo_on;
    logic       fwd_run;
    logic       bk_run;
    logic       dma_en;
    logic [4:0] cnt_q;
    logic       full;
    logic       empty;
    logic       chg_q;
    logic       head_ok;
    logic [8:0] rd_q;

    assign mode    = mode_t'(ecr_q[5:3]);
    assign dma_en  = ecr_q[1] && !ecr_q[0];
    // standard and printer FIFO modes are forward only
    assign dir_eff = (mode == M_STD || mode == M_PPF) ? 1'b0 : ctrl_q[`C_DIR];
    assign fifo_on = (mode == M_PPF) || (mode == M_ECP) || (mode == M_TEST);
    assign fwd_run = (mode == M_PPF) || (mode == M_ECP && !dir_eff);
    assign bk_run  = (mode == M_ECP) && dir_eff;
    assign full    = cnt_q == 5'(`FIFO_DEPTH);
    assign empty   = cnt_q == 5'h00;
    // read data of the memory lag one cycle after any change
    assign head_ok = !empty && !chg_q;

    //--------------------------------------------------------
    // bus slave
    //--------------------------------------------------------
    logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic       aw_full_q, w_full_q;
    logic [5:0] waddr_q;
    logic [7:0] wdat_q;
    logic       wstb_q;
    logic       aw_hs, w_hs, ar_hs, do_wr, aw_full_d, w_full_d, wen;
    logic [5:0] ridx;
    logic [7:0] rmux;
    logic       push_ok, pop_ok;

    assign aw_hs     = AXI_REQ.awvalid && awready_q;
    assign w_hs      = AXI_REQ.wvalid && wready_q;
    assign ar_hs     = AXI_REQ.arvalid && arready_q;
    assign do_wr     = aw_full_q && w_full_q && !bvalid_q;
    assign aw_full_d = aw_hs || (aw_full_q && !do_wr);
    assign w_full_d  = w_hs || (w_full_q && !do_wr);
    assign wen       = do_wr && wstb_q && (waddr_q <= `IDX_LAST);
    assign ridx      = AXI_REQ.araddr[7:2];

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OK;
            waddr_q   <= 6'h00;
            wdat_q    <= 8'h00;
            wstb_q    <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q  <= !w_full_d;
            bvalid_q  <= do_wr || (bvalid_q && !AXI_REQ.bready);
            if (aw_hs) begin
                waddr_q <= AXI_REQ.awaddr[7:2];
            end
            if (w_hs) begin
                wdat_q <= AXI_REQ.wdata[7:0];
                wstb_q <= AXI_REQ.wstrb[0];
            end
            if (do_wr) begin
                bresp_q <= (waddr_q <= `IDX_LAST) ? `RESP_OK : `RESP_ERR;
            end
        end
    end

    // fifo port reads pop in test mode and ECP reverse; hold arready low until the head word settles
    logic sw_rd_fifo, sw_pop;
    assign sw_rd_fifo = (mode == M_TEST) || bk_run;
    assign sw_pop     = ar_hs && ridx == `IDX_FIFO && sw_rd_fifo && !empty;

    always_comb begin
        unique case (ridx)
            `IDX_DATA: rmux = dir_eff ? CABLE_IN.pd : data_q;
            `IDX_STAT: rmux = {~CABLE_IN.busy, CABLE_IN.ack_n, CABLE_IN.pe, CABLE_IN.slct,
                               CABLE_IN.err_n, 3'h0};
            `IDX_CTRL: rmux = {2'h0, dir_eff, ctrl_q[`C_IRQ], ~CABLE_IN.ctl[3], CABLE_IN.ctl[2],
                               ~CABLE_IN.ctl[1], ~CABLE_IN.ctl[0]};
            `IDX_FIFO: rmux = (mode == M_CFG) ? `CFGA_VAL : (sw_rd_fifo ? rd_q[7:0] : 8'h00);
            `IDX_CFGB: rmux = (mode == M_CFG) ? cfgb_q : 8'h00;
            `IDX_ECR:  rmux = {ecr_q, full, empty};
            default:   rmux = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `RESP_OK;
        end else begin
            arready_q <= !(ar_hs || (rvalid_q && !AXI_REQ.rready)) && !(push_ok || pop_ok);
            rvalid_q  <= ar_hs || (rvalid_q && !AXI_REQ.rready);
            if (ar_hs) begin
                rdata_q <= {24'h00_0000, rmux};
                rresp_q <= (ridx <= `IDX_LAST) ? `RESP_OK : `RESP_ERR;
            end
        end
    end

    assign AXI_RSP = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                       arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

    //--------------------------------------------------------
    // register writes
    //--------------------------------------------------------
    logic sw_push, sw_cmd;
    // in ECP forward a data register write queues a command byte
    assign sw_cmd  = wen && waddr_q == `IDX_DATA && mode == M_ECP && !dir_eff;
    assign sw_push = sw_cmd || (wen && waddr_q == `IDX_FIFO && (fwd_run || mode == M_TEST));

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            data_q <= `DATA_RST;
            ctrl_q <= `CTRL_RST;
            cfgb_q <= `CFGB_RST;
            ecr_q  <= `ECR_RST;
        end else if (wen) begin
            if (waddr_q == `IDX_DATA && !sw_cmd) begin
                data_q <= wdat_q;
            end
            if (waddr_q == `IDX_CTRL) begin
                ctrl_q <= wdat_q;
            end
            if (waddr_q == `IDX_CFGB && mode == M_CFG) begin
                cfgb_q <= wdat_q;
            end
            if (waddr_q == `IDX_ECR) begin
                ecr_q <= wdat_q[7:2];
            end
        end
    end

    //--------------------------------------------------------
    // fifo
    //--------------------------------------------------------
    logic [`FIFO_AW-1:0] wp_q, rp_q;
    logic       flush, push, pop, f_pop, b_push, dma_push, dma_pop;
    logic [8:0] wd;
    logic [7:0] bbyte_q;
    mode_t      mode_q;

    assign flush   = !fifo_on || mode != mode_q;
    assign push    = sw_push || dma_push || b_push;
    assign pop     = f_pop || sw_pop || dma_pop;
    assign push_ok = push && !full && !flush;
    assign pop_ok  = pop && !empty && !flush;
    assign wd      = b_push ? {1'b0, bbyte_q} : (sw_push ? {sw_cmd, wdat_q} : {1'b0, DMA_WDATA});

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wp_q   <= '0;
            rp_q   <= '0;
            cnt_q  <= 5'h00;
            chg_q  <= 1'b1;
            mode_q <= M_STD;
        end else begin
            mode_q <= mode;
            chg_q  <= push_ok || pop_ok || flush;
            if (flush) begin
                wp_q  <= '0;
                rp_q  <= '0;
                cnt_q <= 5'h00;
            end else begin
                wp_q  <= wp_q + `FIFO_AW'(push_ok);
                rp_q  <= rp_q + `FIFO_AW'(pop_ok);
                cnt_q <= cnt_q + 5'(push_ok) - 5'(pop_ok);
            end
        end
    end

    ecp_fifo_mem u_mem (
        .clk  (SYS_CLK),
        .we   (push_ok),
        .wa   (wp_q),
        .wd   (wd),
        .ra   (rp_q),
        .rd_q (rd_q)
    );

    //--------------------------------------------------------
    // forward write engine
    //--------------------------------------------------------
    fst_t       fst_q, fst_d;
    logic [8:0] fbyte_q, fbyte_d;
    logic [6:0] tmr_q;

    always_comb begin
        fst_d   = fst_q;
        fbyte_d = fbyte_q;
        if (!fwd_run) begin
            fst_d = F_IDLE;
        end else begin
            unique case (fst_q)
                F_IDLE: if (head_ok) begin
                    fst_d   = F_SETUP;
                    fbyte_d = rd_q;
                end
                F_SETUP: if (!CABLE_IN.busy) fst_d = F_STB;
                F_STB: if (mode == M_PPF ? tmr_q == STB_LAST : CABLE_IN.busy) fst_d = F_END;
                F_END: if (!CABLE_IN.busy) fst_d = F_IDLE;
            endcase
        end
    end

    // the byte leaves the fifo when its cycle ends
    assign f_pop = fwd_run && fst_q == F_END && !CABLE_IN.busy;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            fst_q   <= F_IDLE;
            fbyte_q <= 9'h000;
            tmr_q   <= 7'h00;
        end else begin
            fst_q   <= fst_d;
            fbyte_q <= fbyte_d;
            tmr_q   <= (fst_q == F_STB) ? tmr_q + 7'h01 : 7'h00;
        end
    end

    //--------------------------------------------------------
    // backward read engine with run-length expansion
    //--------------------------------------------------------
    bst_t       bst_q, bst_d;
    logic       bbusy_q, rle_q;
    logic [6:0] rlc_q, left_q;
    logic [7:0] exp_n_q;

    always_comb begin
        bst_d = bst_q;
        if (!bk_run) begin
            bst_d = B_IDLE;
        end else begin
            unique case (bst_q)
                B_IDLE: if (!full) bst_d = B_REQ;
                B_REQ: if (!CABLE_IN.ack_n) bst_d = B_ACK;
                B_ACK: if (CABLE_IN.ack_n) bst_d = B_LATCH;
                B_LATCH: begin
                    if (rle_q) bst_d = B_EXP;
                    else if (!(bbusy_q && full)) bst_d = B_IDLE;
                end
                B_EXP: if (!full && left_q == 7'h00) bst_d = B_IDLE;
                default: bst_d = B_IDLE;
            endcase
        end
    end

    assign b_push = bk_run && !full &&
                    ((bst_q == B_LATCH && !rle_q && bbusy_q) || bst_q == B_EXP);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            bst_q   <= B_IDLE;
            bbyte_q <= 8'h00;
            bbusy_q <= 1'b0;
            rle_q   <= 1'b0;
            rlc_q   <= 7'h00;
            left_q  <= 7'h00;
            exp_n_q <= 8'h00;
        end else begin
            bst_q <= bst_d;
            if (!bk_run) begin
                rle_q <= 1'b0;
            end else if (bst_q == B_ACK && CABLE_IN.ack_n) begin
                bbyte_q <= CABLE_IN.pd;
                bbusy_q <= CABLE_IN.busy;
            end else if (bst_q == B_LATCH && rle_q) begin
                rle_q   <= 1'b0;
                left_q  <= rlc_q;
                exp_n_q <= 8'h00;
            end else if (bst_q == B_LATCH && !bbusy_q && !bbyte_q[7]) begin
                rle_q <= 1'b1;
                rlc_q <= bbyte_q[6:0];
            end else if (bst_q == B_EXP && !full) begin
                left_q  <= left_q - 7'h01;
                exp_n_q <= exp_n_q + 8'h01;
            end
        end
    end

    //--------------------------------------------------------
    // dma
    //--------------------------------------------------------
    logic dreq_d;
    assign dreq_d   = dma_en && !DMA_ACK && ((fwd_run && !full) || (bk_run && head_ok));
    assign dma_push = DMA_ACK && dma_en && fwd_run;
    assign dma_pop  = DMA_ACK && dma_en && bk_run;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DMA_REQ   <= 1'b0;
            DMA_RDATA <= 8'h00;
        end else begin
            DMA_REQ <= dreq_d;
            if (dma_pop) begin
                DMA_RDATA <= rd_q[7:0];
            end
        end
    end

    //--------------------------------------------------------
    // cable pins
    //--------------------------------------------------------
    logic [3:0] lvl;
    logic       fwd_act;
    assign fwd_act = fst_d != F_IDLE;

    always_comb begin
        lvl = {~ctrl_q[`C_SELECT_IN_LINE], ctrl_q[`C_INIT], ~ctrl_q[`C_AFD], ~ctrl_q[`C_STB]};
        if (fwd_run) begin
            lvl[0] = !(fst_d == F_STB);
            if (mode == M_ECP) lvl[1] = !fbyte_d[8];
        end else if (bk_run) begin
            lvl[0] = 1'b1;
            lvl[1] = bst_d == B_ACK;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CABLE_OUT <= '{ctl: 4'hF, pd: 8'h00};
            CABLE_OE  <= '{ctl: 4'h0, pd: 8'h00};
        end else begin
            CABLE_OUT.ctl <= lvl;
            CABLE_OE.ctl  <= (mode == M_STD) ? ~lvl : 4'hF;
            CABLE_OUT.pd  <= (fwd_run && fwd_act) ? fbyte_d[7:0] : data_q;
            CABLE_OE.pd   <= {8{!dir_eff}};
        end
    end

    //--------------------------------------------------------
    // checks
    //--------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    strobe_busy_low_a: assert property ($fell(CABLE_OUT.ctl[0]) && fwd_run |-> $past(!CABLE_IN.busy))
        else $error("strobe asserted while busy high");
    ecp_strobe_hold_a: assert property (mode == M_ECP && fst_q == F_STB && !CABLE_IN.busy && fwd_run
        ##1 mode == M_ECP && fwd_run |-> !CABLE_OUT.ctl[0])
        else $error("ecp strobe dropped before busy");
    strobe_release_a: assert property (fwd_run && fst_q == F_STB && mode == M_ECP && CABLE_IN.busy
        |=> CABLE_OUT.ctl[0])
        else $error("strobe not released on busy");
    lines_hold_a: assert property (fst_q == F_END && CABLE_IN.busy && fwd_run
        |=> $stable(CABLE_OUT.pd) && $stable(CABLE_OUT.ctl[1]))
        else $error("lines changed while busy high");
    std_open_drain_a: assert property (mode == M_STD |=> (CABLE_OUT.ctl & CABLE_OE.ctl) == 4'h0
        && CABLE_OE.pd == 8'hFF)
        else $error("standard mode pin drive wrong");
    test_no_cycles_a: assert property (mode == M_TEST && $past(mode) == M_TEST
        |-> fst_q == F_IDLE && bst_q == B_IDLE)
        else $error("cycle issued in fifo test mode");
    cmd_discard_a: assert property (bk_run && bst_q == B_LATCH && !rle_q && !bbusy_q && bbyte_q[7]
        |-> !b_push ##1 !rle_q)
        else $error("discarded command was used");
    rle_count_a: assert property (bk_run && bst_q == B_EXP && !full && left_q == 7'h00
        |-> exp_n_q == {1'b0, rlc_q})
        else $error("expansion count wrong");
    afd_ack_a: assert property (bk_run && bst_q == B_REQ && !CABLE_IN.ack_n
        |=> CABLE_OUT.ctl[1] && bst_q == B_ACK)
        else $error("autofeed not raised on ack");
    dma_mode_a: assert property (DMA_REQ |-> $past(mode) == M_PPF || $past(mode) == M_ECP)
        else $error("dma request outside fifo modes");

    fwd_cycle_c: cover property (fwd_run && fst_q == F_END ##1 fst_q == F_IDLE);
    rle_exp_c:   cover property (bst_q == B_EXP && left_q == 7'h02 ##1 bst_q == B_EXP);
    dma_bk_c:    cover property (DMA_REQ && DMA_ACK && bk_run);

endmodule // ecp_port

`default_nettype wire
